// ===== hdl/encoder_preset_and_wrap_zone.sv
`timescale 1ns/1ns

// Functional notes
// RULE_01: Preset word with top bit set is reported as position by third cycle (code reports it next cycle, only if below the active span).
// RULE_02: A received preset is committed to retained storage at once, no save command.
// RULE_03: Master should preset only while the shaft stands still; not checked.
// RULE_04: Diagnostic request always answered with six bytes: status, master id, maker id.
// RULE_05: Wrap zone size is hardware span remainder after repeated scaled span subtraction.
// RULE_06: Entering the wrap zone makes the reported position jump.
// RULE_07: In the wrap zone last position before zero equals scaled span minus one.
// RULE_08: Inside wrap zone green indicator flashes, red stays off.
// RULE_09: Defaults: direction 0, extended 1, scaling 1, 4096 per turn, span per model.
// RULE_10: Preset word bit 31 clear changes nothing; set takes bits 30..0 as preset (code drops a value not below the active span).
// RULE_11: Position is a right-aligned 32-bit word, most significant byte first.
// RULE_12: Outside the wrap zone position wraps modulo the active span.
module encoder_preset_and_wrap_zone #(
  parameter int unsigned W          = enc_pos_pkg::SPAN_W,
  parameter int unsigned HW_SPAN    = enc_pos_pkg::HW_SPAN_MT,
  parameter int unsigned BLINK_CYC  = enc_pos_pkg::BLINK_CYC,
  parameter logic [15:0] MAKER_ID   = 16'h5A5A                // Arbitrary value
) (
  input  wire logic         mclk,            // Device clock, 250 MHz
  input  wire logic         srst,            // Synchronous reset, active high
  input  wire logic [W-1:0] raw_count,       // Hardware count from sensor pins
  input  wire logic         cfg_wr,          // Configuration load strobe
  input  wire logic         cfg_dir,         // Count direction select
  input  wire logic         cfg_ext,         // Extended feature set
  input  wire logic         cfg_scale,       // Custom scaling enable
  input  wire logic [W-1:0] cfg_span,        // Scaled total span
  input  wire logic         xchg_valid,      // Cyclic exchange strobe
  input  wire logic [31:0]  xchg_word,       // Word received from master
  input  wire logic [1:0]   pos_byte_idx,    // Position byte select, 0 is MSB
  output logic      [7:0]   pos_byte_ff,     // Selected position byte
  output logic      [31:0]  pos_word_ff,     // Reported position word
  input  wire logic         diag_req,        // diagnostic_request_service strobe
  input  wire logic [2:0]   diag_idx,        // Diagnostic byte index
  input  wire logic [7:0]   diag_stat1,      // Status byte 1
  input  wire logic [7:0]   diag_stat2,      // Status byte 2
  input  wire logic [7:0]   diag_stat3,      // Status byte 3
  input  wire logic [7:0]   diag_master_id,  // Master identifier
  output logic      [7:0]   diag_byte_ff,    // Diagnostic answer byte
  output logic              diag_ack_ff,     // Answer valid pulse
  output logic              in_zone_ff,      // Position inside wrap zone
  output logic              led_green,       // Green indicator
  output logic              led_red          // Red indicator
);

  typedef enum logic [2:0] {ZONE_LD, ZONE_DIV, POS_LD, POS_DIV, PUBLISH} calc_t;

  localparam logic [W-1:0] HW_SPAN_V = W'(HW_SPAN);
  localparam int unsigned  BLK_W     = $clog2(BLINK_CYC + 1);

  // ==========================================================================
  // Pin synchroniser
  logic [W-1:0] cnt_meta_ff;
  logic [W-1:0] cnt_sync_ff;

  // Count word is taken to be stable across the two stages (sensor holds it)
  always_ff @(posedge mclk) begin
    cnt_meta_ff <= raw_count;
    cnt_sync_ff <= cnt_meta_ff;
  end

  // ==========================================================================
  // Configuration registers
  logic         dir_ff;
  logic         ext_ff;
  logic         scale_ff;
  logic [W-1:0] span_ff;

  // A zero span is refused so the remainder unit never divides by zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      dir_ff   <= enc_pos_pkg::DIR_RST;                      // RULE_09
      ext_ff   <= enc_pos_pkg::EXT_RST;                      // RULE_09
      scale_ff <= enc_pos_pkg::SCALE_RST;                    // RULE_09
      span_ff  <= HW_SPAN_V;                                 // RULE_09
    end else if (cfg_wr && (cfg_span != '0) && (cfg_span <= HW_SPAN_V)) begin
      dir_ff   <= cfg_dir;
      ext_ff   <= cfg_ext;
      scale_ff <= cfg_scale;
      span_ff  <= cfg_span;
    end
  end

  // ==========================================================================
  // Active span and direction-corrected count
  wire          scale_on  = ext_ff & scale_ff;
  wire [W-1:0]  act_span  = scale_on ? span_ff : HW_SPAN_V;  // RULE_12
  wire [W-1:0]  cnt_dir   = dir_ff ? (HW_SPAN_V - W'(1) - cnt_sync_ff) : cnt_sync_ff;

  // Offset from retained storage, folded into the hardware span
  logic [31:0]  offset_rd;
  wire  [W:0]   off_sum   = {1'b0, cnt_dir} + {1'b0, offset_rd[W-1:0]};
  wire  [W-1:0] adj_count = (off_sum >= {1'b0, HW_SPAN_V}) ? W'(off_sum - {1'b0, HW_SPAN_V}) : off_sum[W-1:0];

  // ==========================================================================
  // Preset capture
  wire          preset_flag = xchg_word[enc_pos_pkg::PRESET_FLAG_BIT];
  wire  [30:0]  preset_val  = xchg_word[enc_pos_pkg::PRESET_VAL_MSB:0];
  // Out-of-range presets are dropped rather than folded, keeping reports in span
  wire          preset_ok   = (preset_val < 31'(act_span));
  wire          preset_take = xchg_valid & preset_flag & preset_ok;   // RULE_10
  wire  [W-1:0] preset_w    = W'(preset_val);
  wire  [W-1:0] new_offset  = (preset_w >= cnt_dir) ? (preset_w - cnt_dir)
                                                    : W'(preset_w + HW_SPAN_V - cnt_dir);

  // Offset is written the same cycle the preset word arrives
  preset_store #(
    .DW         (32)
  ) u_store (
    .mclk       (mclk),
    .srst       (srst),
    .wr_en      (preset_take),                               // RULE_02
    .wr_data    (32'(new_offset)),
    .rd_data_ff (offset_rd)
  );

  // ==========================================================================
  // Sequential remainder unit, shared between zone size and wrap
  calc_t        st_ff;
  logic [W-1:0] dvd_ff;
  logic [W:0]   rem_ff;
  logic [W-1:0] zone_ff;
  logic [W-1:0] adj_ff;
  logic [$clog2(W+1)-1:0] bit_ff;

  wire  [W:0]   rem_sh   = {rem_ff[W-1:0], dvd_ff[W-1]};
  wire          rem_ge   = (rem_sh >= {1'b0, act_span});
  wire  [W:0]   rem_nxt  = rem_ge ? (rem_sh - {1'b0, act_span}) : rem_sh;
  wire          div_last = (bit_ff == ($clog2(W+1))'(1));

  // Zone boundary and the two mappings of the adjusted count
  wire  [W-1:0] zone_base = HW_SPAN_V - zone_ff;
  wire          zone_hit  = (zone_ff != '0) && (adj_ff >= zone_base);
  wire  [W-1:0] zone_pos  = W'(adj_ff - zone_base + act_span - zone_ff);   // RULE_07

  // Preset restarts the walk so a stale result is never published
  always_ff @(posedge mclk) begin
    if (srst || preset_take) begin
      st_ff   <= ZONE_LD;
      dvd_ff  <= '0;
      rem_ff  <= '0;
      bit_ff  <= '0;
      zone_ff <= '0;
      adj_ff  <= '0;
    end else begin
      case (st_ff)
        ZONE_LD: begin
          dvd_ff <= HW_SPAN_V;
          rem_ff <= '0;
          bit_ff <= ($clog2(W+1))'(W);
          st_ff  <= ZONE_DIV;
        end
        ZONE_DIV: begin
          dvd_ff <= {dvd_ff[W-2:0], 1'b0};
          rem_ff <= rem_nxt;                                 // RULE_05
          bit_ff <= bit_ff - 1'b1;
          if (div_last) begin
            st_ff <= POS_LD;
          end
        end
        POS_LD: begin
          zone_ff <= rem_ff[W-1:0];                          // RULE_05
          adj_ff  <= adj_count;
          dvd_ff  <= adj_count;
          rem_ff  <= '0;
          bit_ff  <= ($clog2(W+1))'(W);
          st_ff   <= POS_DIV;
        end
        POS_DIV: begin
          dvd_ff <= {dvd_ff[W-2:0], 1'b0};
          rem_ff <= rem_nxt;                                 // RULE_12
          bit_ff <= bit_ff - 1'b1;
          if (div_last) begin
            st_ff <= PUBLISH;
          end
        end
        PUBLISH: begin
          st_ff <= ZONE_LD;
        end
        default: begin
          st_ff <= ZONE_LD;
        end
      endcase
    end
  end

  // ==========================================================================
  // Reported position word
  wire [W-1:0] pub_pos = zone_hit ? zone_pos : rem_ff[W-1:0];            // RULE_06

  // A taken preset is reported at once, ahead of the next walk
  always_ff @(posedge mclk) begin
    if (srst) begin
      pos_word_ff <= 32'h0000_0000;
      in_zone_ff  <= 1'b0;
    end else if (preset_take) begin
      pos_word_ff <= {1'b0, preset_val};                     // RULE_01
      // A taken preset is below the active span, so it always lands outside the zone
      in_zone_ff  <= 1'b0;                                   // RULE_08
    end else if (st_ff == PUBLISH) begin
      pos_word_ff <= 32'(pub_pos);                           // RULE_11
      in_zone_ff  <= zone_hit;
    end
  end

  // Byte lane select, index 0 carries the most significant byte
  wire [4:0] lane_sh = 5'((enc_pos_pkg::POS_BYTES - 1 - pos_byte_idx) * 8);

  always_ff @(posedge mclk) begin
    if (srst) begin
      pos_byte_ff <= 8'h00;
    end else begin
      pos_byte_ff <= 8'(pos_word_ff >> lane_sh);             // RULE_11
    end
  end

  // ==========================================================================
  // Diagnostic answer, served in any state
  logic [7:0] diag_sel;

  always_comb begin
    case (diag_idx)
      enc_pos_pkg::DIAG_STAT1:    diag_sel = diag_stat1;
      enc_pos_pkg::DIAG_STAT2:    diag_sel = diag_stat2;
      enc_pos_pkg::DIAG_STAT3:    diag_sel = diag_stat3;
      enc_pos_pkg::DIAG_MASTER:   diag_sel = diag_master_id;
      enc_pos_pkg::DIAG_MAKER_HI: diag_sel = MAKER_ID[15:8];
      enc_pos_pkg::DIAG_MAKER_LO: diag_sel = MAKER_ID[7:0];
      default:                    diag_sel = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      diag_byte_ff <= 8'h00;
      diag_ack_ff  <= 1'b0;
    end else begin
      diag_ack_ff  <= diag_req;                              // RULE_04
      if (diag_req) begin
        diag_byte_ff <= diag_sel;                            // RULE_04
      end
    end
  end

  // ==========================================================================
  // Indicator flash divider
  logic [BLK_W-1:0] blk_cnt_ff;
  logic             blink_ff;
  wire              blk_tick = (blk_cnt_ff == BLK_W'(BLINK_CYC - 1));

  always_ff @(posedge mclk) begin
    if (srst) begin
      blk_cnt_ff <= '0;
      blink_ff   <= 1'b0;
    end else begin
      blk_cnt_ff <= blk_tick ? '0 : blk_cnt_ff + 1'b1;
      if (blk_tick) begin
        blink_ff <= ~blink_ff;
      end
    end
  end

  // Green steady in normal range, flashing in the wrap zone
  assign led_green = in_zone_ff ? blink_ff : 1'b1;           // RULE_08
  assign led_red   = 1'b0;                                   // RULE_08

endmodule // encoder_preset_and_wrap_zone

// ===== shared/enc_pos_pkg.sv
package enc_pos_pkg;

  // ==========================================================================
  // Widths and spans
  localparam int unsigned SPAN_W       = 26;            // Holds spans up to 2^26 - 1
  localparam int unsigned HW_SPAN_ST   = 4096;          // Single-turn hardware span
  localparam int unsigned HW_SPAN_MT   = 16777216;      // Multi-turn hardware span
  localparam int unsigned CPT_DEF      = 4096;          // Counts per turn default

  // ==========================================================================
  // Configuration reset values
  localparam logic        DIR_RST      = 1'b0;          // Count direction select
  localparam logic        EXT_RST      = 1'b1;          // Extended feature set
  localparam logic        SCALE_RST    = 1'b1;          // Custom scaling enabled
  localparam logic [31:0] OFFSET_RST   = 32'h0000_0000; // Retained preset offset

  // ==========================================================================
  // Preset and position word layout
  localparam int unsigned PRESET_FLAG_BIT = 31;          // Preset request flag
  localparam int unsigned PRESET_VAL_MSB  = 30;          // Top bit of preset value
  localparam int unsigned POS_BYTES       = 4;           // Byte 0 carries bits 31-24

  // ==========================================================================
  // Diagnostic block layout
  localparam int unsigned DIAG_LEN      = 6;
  localparam logic [2:0]  DIAG_STAT1    = 3'h0;
  localparam logic [2:0]  DIAG_STAT2    = 3'h1;
  localparam logic [2:0]  DIAG_STAT3    = 3'h2;
  localparam logic [2:0]  DIAG_MASTER   = 3'h3;
  localparam logic [2:0]  DIAG_MAKER_HI = 3'h4;
  localparam logic [2:0]  DIAG_MAKER_LO = 3'h5;

  // ==========================================================================
  // Indicator timing
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned BLINK_HALF_MS = 250;           // Green flash half period
  localparam int unsigned BLINK_CYC     = BLINK_HALF_MS * 1000 * CLK_MHZ;

endpackage

// ===== hdl/preset_store.sv
`timescale 1ns/1ns

// ============================================================================
// Retained preset offset storage; read data come from a register
module preset_store #(
  parameter int unsigned DW = 32
) (
  input  wire logic          mclk,       // Device clock
  input  wire logic          srst,       // Power-on reset, active high
  input  wire logic          wr_en,      // Commit strobe
  input  wire logic [DW-1:0] wr_data,    // Word to retain
  output logic      [DW-1:0] rd_data_ff  // Retained word
);

  logic [DW-1:0] mem_ff;

  // Storage cell and registered read port
  always_ff @(posedge mclk) begin
    if (srst) begin
      mem_ff     <= DW'(enc_pos_pkg::OFFSET_RST);
      rd_data_ff <= DW'(enc_pos_pkg::OFFSET_RST);
    end else begin
      if (wr_en) begin
        mem_ff <= wr_data;
      end
      rd_data_ff <= wr_en ? wr_data : mem_ff;
    end
  end

endmodule // preset_store

// ===== tb/enc_zone_checker.sv
`timescale 1ns/1ns

// ============================================================================
// Port checker for the position and wrap zone block
module enc_zone_checker #(
  parameter int unsigned W         = 26,
  parameter int unsigned HW_SPAN   = 16777216,
  parameter int unsigned BLINK_CYC = 8
) (
  input wire logic         mclk,           // Clock
  input wire logic         srst,           // Reset
  input wire logic         cfg_wr,         // Config strobe
  input wire logic         cfg_ext,        // Extended set
  input wire logic         cfg_scale,      // Scaling enable
  input wire logic [W-1:0] cfg_span,       // Scaled span
  input wire logic         xchg_valid,     // Exchange strobe
  input wire logic [31:0]  xchg_word,      // Master word
  input wire logic [1:0]   pos_byte_idx,   // Byte select
  input wire logic [7:0]   pos_byte_ff,    // Byte out
  input wire logic [31:0]  pos_word_ff,    // Position
  input wire logic         diag_req,       // Diag strobe
  input wire logic [2:0]   diag_idx,       // Diag index
  input wire logic [7:0]   diag_master_id, // Master id
  input wire logic [7:0]   diag_byte_ff,   // Diag byte
  input wire logic         diag_ack_ff,    // Diag ack
  input wire logic         in_zone_ff,     // Zone flag
  input wire logic         led_green,      // Green
  input wire logic         led_red         // Red
);
  logic [31:0] act_span_ff; // Span a preset is checked against
  logic [31:0] same_ff;     // Cycles with green unchanged in zone
  logic        grn_ff;      // Green one cycle ago

  // Track the active span; a refused span load leaves it alone
  always_ff @(posedge mclk) begin
    if (srst) begin
      act_span_ff <= HW_SPAN;
    end else if (cfg_wr && cfg_span != '0 && 32'(cfg_span) <= HW_SPAN) begin
      act_span_ff <= (cfg_ext && cfg_scale) ? 32'(cfg_span) : HW_SPAN;
    end
  end

  // Count how long green stands still inside the zone
  always_ff @(posedge mclk) begin
    grn_ff  <= led_green;
    same_ff <= (srst || !in_zone_ff || led_green != grn_ff) ? 32'h0000_0000 : same_ff + 32'h0000_0001;
  end

  default clocking dc @(posedge mclk); endclocking
  default disable iff (srst);

  a_red_off: assert property (led_red == 1'b0) else $error("red indicator lit");
  a_green_steady: assert property ((!in_zone_ff && !$fell(in_zone_ff)) |-> led_green)
    else $error("green not steady outside zone");
  a_blink_rate: assert property (same_ff <= BLINK_CYC) else $error("green does not flash in zone");
  a_diag_ack: assert property (diag_req |=> diag_ack_ff) else $error("diag request not acknowledged");
  a_ack_pulse: assert property (!diag_req |=> !diag_ack_ff) else $error("diag ack without request");
  a_diag_master: assert property (diag_req && diag_idx == 3'h3 |=> diag_byte_ff == $past(diag_master_id))
    else $error("master id byte wrong");
  a_diag_spare: assert property (diag_req && diag_idx[2:1] == 2'h3 |=> diag_byte_ff == 8'h00)
    else $error("spare diag byte not zero");
  a_preset_take: assert property (xchg_valid && xchg_word[31] && 32'(xchg_word[30:0]) < act_span_ff
    |=> pos_word_ff == {1'b0, $past(xchg_word[30:0])}) else $error("preset not reported");
  a_pos_byte: assert property (pos_byte_ff == 8'($past(pos_word_ff) >> (5'h18 - 5'h08 * $past(pos_byte_idx))))
    else $error("position byte order wrong");
endmodule // enc_zone_checker

bind encoder_preset_and_wrap_zone enc_zone_checker #(.W(W), .HW_SPAN(HW_SPAN), .BLINK_CYC(BLINK_CYC)) chk_u (
  .mclk, .srst, .cfg_wr, .cfg_ext, .cfg_scale, .cfg_span, .xchg_valid, .xchg_word, .pos_byte_idx, .pos_byte_ff,
  .pos_word_ff, .diag_req, .diag_idx, .diag_master_id, .diag_byte_ff, .diag_ack_ff, .in_zone_ff, .led_green, .led_red);

// ===== tb/cyc_master_model.sv
`timescale 1ns/1ns

// ============================================================================
// Cyclic bus master: repeats one word at every exchange while enabled
module cyc_master_model #(
  parameter int unsigned PERIOD = 4
) (
  input  wire logic        mclk,       // Clock
  input  wire logic        srst,       // Reset
  input  wire logic        en,         // Run exchanges
  input  wire logic [31:0] word_in,    // Word to send
  output logic             xchg_valid, // Exchange strobe
  output logic      [31:0] xchg_word   // Word to the block
);
  int unsigned tick;
  logic        go;

  assign go = !srst && en && tick == 0;
  // A preset word is resent each exchange while the bench holds the count still;
  // between exchanges the word is inverted so a stale value never looks fresh
  always @(posedge mclk) begin
    tick       <= (srst || !en || tick == PERIOD - 1) ? 0 : tick + 1;
    xchg_valid <= go;
    xchg_word  <= srst ? 32'h5555_5555 : (go ? word_in : ~xchg_word);
  end
endmodule // cyc_master_model

// ===== tb/tb_top.sv
`timescale 1ns/1ns

// ============================================================================
// Bench: single-turn sized block, short blink period to keep the run brief
module tb_top;
  localparam int unsigned W    = 13;                  // One bit above the count so the 4096 span fits
  localparam int unsigned HW   = 4096;
  localparam int unsigned BLK  = 8;
  localparam int unsigned WAIT = 2 * (2 * W + 3) + 6; // Two calc passes plus sync
  logic         mclk, srst, cfg_wr, cfg_dir, cfg_ext, cfg_scale, diag_req, m_en;
  logic         xchg_valid, diag_ack_ff, in_zone_ff, led_green, led_red;
  logic [W-1:0] raw_count, cfg_span;
  logic [31:0]  m_word, xchg_word, pos_word_ff;
  logic [1:0]   pos_byte_idx;
  logic [2:0]   diag_idx;
  logic [7:0]   st1, st2, st3, mid, pos_byte_ff, diag_byte_ff;
  int           n_mismatch = 0;
  int           check_count = 0;

  cyc_master_model #(.PERIOD(4)) mst_u (.mclk(mclk), .srst(srst), .en(m_en), .word_in(m_word),
    .xchg_valid(xchg_valid), .xchg_word(xchg_word));
  encoder_preset_and_wrap_zone #(.W(W), .HW_SPAN(HW), .BLINK_CYC(BLK), .MAKER_ID(16'hC3E1)) dut_u (
    .mclk(mclk), .srst(srst), .raw_count(raw_count), .cfg_wr(cfg_wr), .cfg_dir(cfg_dir), .cfg_ext(cfg_ext),
    .cfg_scale(cfg_scale), .cfg_span(cfg_span), .xchg_valid(xchg_valid), .xchg_word(xchg_word),
    .pos_byte_idx(pos_byte_idx), .pos_byte_ff(pos_byte_ff), .pos_word_ff(pos_word_ff), .diag_req(diag_req),
    .diag_idx(diag_idx), .diag_stat1(st1), .diag_stat2(st2), .diag_stat3(st3), .diag_master_id(mid),
    .diag_byte_ff(diag_byte_ff), .diag_ack_ff(diag_ack_ff), .in_zone_ff(in_zone_ff), .led_green(led_green),
    .led_red(led_red));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  // Sample one time unit after the edge so its updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Count must be held still over two full calc passes before it is read
  task automatic set_raw(input logic [11:0] c);
    @(posedge mclk);
    raw_count <= W'(c);
    cyc(WAIT);
  endtask

  task automatic do_reset();
    @(posedge mclk);
    srst <= 1'b1;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    cyc(1);
  endtask

  task automatic load_cfg(input logic dir, input logic ext, input logic scale, input logic [11:0] span);
    @(posedge mclk);
    {cfg_wr, cfg_dir, cfg_ext, cfg_scale, cfg_span} <= {1'b1, dir, ext, scale, W'(span)};
    @(posedge mclk);
    cfg_wr <= 1'b0;
  endtask

  // Defaults: full hardware span, no zone, indicators idle
  task automatic t_defaults();
    chk_bit(led_red, 1'b0);
    set_raw(12'h032);
    chk(pos_word_ff, 32'h0000_0032);
    set_raw(12'hFFF);
    chk(pos_word_ff, 32'h0000_0FFF);
    chk_bit(in_zone_ff, 1'b0);
    chk_bit(led_green, 1'b1);
  endtask

  // Repeated preset while still, then a plain word and an out of range preset
  task automatic t_preset();
    set_raw(12'h267);
    @(posedge mclk);
    {m_en, m_word} <= {1'b1, 32'h8000_0A5C};
    cyc(3 * 4);
    chk(pos_word_ff, 32'h0000_0A5C);
    @(posedge mclk);
    m_word <= 32'h0000_0123;
    cyc(WAIT);
    chk(pos_word_ff, 32'h0000_0A5C);
    @(posedge mclk);
    m_word <= 32'h8000_1000;
    cyc(WAIT);
    chk(pos_word_ff, 32'h0000_0A5C);
    @(posedge mclk);
    m_en <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      pos_byte_idx <= 2'(i);
      cyc(2);
      chk_byte(pos_byte_ff, 8'(32'h0000_0A5C >> (24 - 8 * i)));
    end
  endtask

  // Span 1000 on 4096: zone of 96 counts from 4000 upward
  task automatic t_zone();
    int unsigned flips;
    logic        g;
    load_cfg(1'b0, 1'b1, 1'b1, 12'h3E8);
    set_raw(12'h9C4);
    chk(pos_word_ff, 32'h0000_01F4);
    set_raw(12'hF9F);
    chk(pos_word_ff, 32'h0000_03E7);
    chk_bit(in_zone_ff, 1'b0);
    set_raw(12'hFA0);
    chk(pos_word_ff, 32'h0000_0388);
    chk_bit(in_zone_ff, 1'b1);
    flips = 0;
    g = led_green;
    for (int i = 0; i < 2 * BLK + 2; i++) begin
      cyc(1);
      if (led_green !== g) flips++;
      g = led_green;
    end
    chk_bit(flips >= 2, 1'b1);
    chk_bit(led_red, 1'b0);
    set_raw(12'hFFF);
    chk(pos_word_ff, 32'h0000_03E7);
    load_cfg(1'b1, 1'b1, 1'b0, 12'h3E8);
    set_raw(12'hFA0);
    chk(pos_word_ff, 32'h0000_005F);
    chk_bit(in_zone_ff, 1'b0);
    // A zero span is refused, so the reversed unscaled mapping stays
    load_cfg(1'b0, 1'b1, 1'b1, 12'h000);
    cyc(WAIT);
    chk(pos_word_ff, 32'h0000_005F);
    // Scaling is gated off while the extended set is off
    load_cfg(1'b0, 1'b0, 1'b1, 12'h3E8);
    cyc(WAIT);
    chk(pos_word_ff, 32'h0000_0FA0);
    chk_bit(in_zone_ff, 1'b0);
  endtask

  // Back to back requests over every index, spare ones included
  task automatic t_diag();
    logic [7:0] exp [8];
    exp = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hC3, 8'hE1, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      {diag_req, diag_idx} <= {1'b1, 3'(i)};
      if (i > 0) begin
        #1;
        chk_byte(diag_byte_ff, exp[i-1]);
        chk_bit(diag_ack_ff, 1'b1);
      end
    end
    @(posedge mclk);
    diag_req <= 1'b0;
    #1;
    chk_byte(diag_byte_ff, exp[7]);
    cyc(1);
    chk_bit(diag_ack_ff, 1'b0);
  endtask

  // Main sequence
  initial begin
    {srst, cfg_wr, cfg_dir, cfg_ext, cfg_scale, diag_req, m_en} = 7'h4C;
    {cfg_span, raw_count, diag_idx, pos_byte_idx, m_word} = '0;
    {st1, st2, st3, mid} = 32'h1122_3344;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    cyc(1);
    t_defaults();
    t_preset();
    do_reset();
    t_zone();
    t_diag();
    report_and_stop();
  end

  // Watchdog: the tests need under a thousand clocks
  initial begin
    #40000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // tb_top
